// ==== tpb_cfg.svh ====
`ifndef TPB_CFG_SVH
`define TPB_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define TPB_OFS_CTRL1 8'h00
`define TPB_OFS_CTRL2 8'h04
`define TPB_OFS_UPPER 8'h08
`define TPB_OFS_RLD_LO 8'h0C
`define TPB_OFS_DUTY_LO 8'h10
`define TPB_OFS_PSC_CNT 8'h14
`define TPB_OFS_BZ_CTRL 8'h18
`define TPB_OFS_IRQ_FLAG 8'h1C
`define TPB_OFS_IRQ_EN 8'h20
`define TPB_OFS_GLOBAL 8'h24

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define TPB_C1_RUN 0
`define TPB_C1_RELOAD 1
`define TPB_C1_ONESHOT 2
`define TPB_C1_PWM_AL 6
`define TPB_C1_PWM_EN 7
`define TPB_C2_SRC 5
`define TPB_C2_EDGE 4
`define TPB_C2_PSC_EN_N 3
`define TPB_UP_RLD_HI 4
`define TPB_UP_DUTY_HI 0
`define TPB_BZ_EN 7
`define TPB_IRQ_UF 3
`define TPB_GLOBAL_GIE 7

// ------------------------------------------------------------
// Reset values and constants
// ------------------------------------------------------------
`define TPB_RST_CTRL1 8'h00
`define TPB_RST_CTRL2 6'h08
`define TPB_RST_BZ_SEL 4'hF
`define TPB_RST_PSC 8'hFF
`define TPB_FREE_START 10'h3FF
`define TPB_RST_RELOAD 10'h3FF

`endif

// ==== tpb_pkg.sv ====
package tpb_pkg;
    typedef logic [9:0] tpb_count_t;
    typedef logic [7:0] tpb_byte_t;
    // Which source currently owns the shared output pin
    typedef enum logic [1:0] {
        TPB_PIN_NONE = 2'b00,
        TPB_PIN_CMP = 2'b01,
        TPB_PIN_PWM = 2'b10,
        TPB_PIN_BUZ = 2'b11
    } tpb_pin_src_t;
endpackage : tpb_pkg

// ==== tpb_prescaler.sv ====
`timescale 1ns/100ps
`include "tpb_cfg.svh"

module tpb_prescaler
    import tpb_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_src_tick,
    input wire logic i_enable_n,
    input wire logic [2:0] i_ratio,
    output logic o_tick,
    output tpb_byte_t o_count
);
    tpb_byte_t next_count;
    tpb_byte_t mask;

    always_comb begin
        next_count = o_count + 8'h01;
        mask = tpb_byte_t'((9'h002 << i_ratio) - 9'h001);
    end

    // ------------------------------------------------------------
    // Free count of source ticks; divide 2^(ratio+1) when enabled
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_count <= `TPB_RST_PSC;
        end else if (i_src_tick) begin
            o_count <= next_count;
        end
    end

    always_comb begin
        if (i_enable_n) begin
            o_tick = i_src_tick;
        end else begin
            o_tick = i_src_tick && ((next_count & mask) == 8'h00);
        end
    end
endmodule : tpb_prescaler

// ==== tpb_timer.sv ====
`timescale 1ns/100ps
`include "tpb_cfg.svh"

// What this block does
// R1: 10-bit down-counter fed by a prescaler
// R2: Reload buffer reaches counter at underflow when running
// R3: Low reload write loads counter while stopped
// R4: Timer read returns live count
// R5: Run enable at first control bit 0
// R6: Source bit 5 picks pin or instruction clock
// R7: Edge bit 4 picks falling or rising edge
// R8: Active-low prescaler enable, ratios 1:2 to 1:256
// R9: Prescaler count readable
// R10: One-shot counts down once to zero
// R11: Free-run restarts from reload or 0x3FF
// R12: Underflow sets flag; gated interrupt request
// R13: Flag stays until software writes zero
// R14: PWM enable drives pin as output
// R15: Polarity bit makes PWM active low
// R16: Duty gives active clocks; zero never active
// R17: Software keeps duty within reload value
// R18: New duty applied only after underflow
// R19: Buzzer enable drives pin as output
// R20: Buzzer source prescaler or timer by top bit
// R21: Pin priority comparator, PWM, then buzzer
// R22: Low bits pick divide or counter bit
// R23: External clock synchronised, edge detected
module tpb_timer
    import tpb_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic i_instr_tick,
    input wire logic i_external_count_clock,
    input wire logic i_cmp_out,
    input wire logic i_cmp_out_enable,
    output logic o_port_b_pin3_out,
    output logic o_port_b_pin3_oe_n,
    output logic o_irq
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    tpb_byte_t ctrl1;
    logic [5:0] ctrl2;
    logic [1:0] reload_hi;
    logic [1:0] duty_hi;
    tpb_count_t reload_val;
    tpb_count_t duty_buf;
    tpb_count_t duty_act;
    tpb_count_t count;
    logic buzzer_enable;
    logic [3:0] buzzer_freq_select;
    logic underflow_flag;
    logic underflow_irq_enable;
    logic global_irq_enable;
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic src_tick;
    logic cnt_tick;
    logic underflow;
    tpb_byte_t prescaler_count_readback;
    logic acc;
    logic wr;
    logic mapped;
    logic pwm_level;
    logic buzzer_wave_out;
    tpb_pin_src_t pin_src;
    logic [31:0] next_rdata;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;

    always_comb begin
        mapped = 1'b1;
        next_rdata = 32'h0000_0000;
        case (paddr)
            `TPB_OFS_CTRL1: next_rdata[7:0] = ctrl1;
            `TPB_OFS_CTRL2: next_rdata[5:0] = ctrl2;
            `TPB_OFS_UPPER: begin
                next_rdata[5:4] = count[9:8]; // [R4]
                next_rdata[1:0] = duty_hi;
            end
            `TPB_OFS_RLD_LO: next_rdata[7:0] = count[7:0]; // [R4]
            `TPB_OFS_DUTY_LO: next_rdata[7:0] = duty_buf[7:0];
            `TPB_OFS_PSC_CNT: begin
                next_rdata[7:0] = prescaler_count_readback; // [R9]
            end
            `TPB_OFS_BZ_CTRL: begin
                next_rdata[7] = buzzer_enable;
                next_rdata[3:0] = buzzer_freq_select;
            end
            `TPB_OFS_IRQ_FLAG: next_rdata[3] = underflow_flag;
            `TPB_OFS_IRQ_EN: next_rdata[3] = underflow_irq_enable;
            `TPB_OFS_GLOBAL: next_rdata[7] = global_irq_enable;
            default: mapped = 1'b0;
        endcase
    end

    // One wait state: answer registered in the first access cycle
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
                pslverr <= !mapped;
            end else begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl1 <= `TPB_RST_CTRL1;
        end else if (wr && paddr == `TPB_OFS_CTRL1) begin
            ctrl1 <= pwdata[7:0];
        end else if (underflow && ctrl1[`TPB_C1_ONESHOT]) begin
            ctrl1[`TPB_C1_RUN] <= 1'b0; // [R10]
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl2 <= `TPB_RST_CTRL2;
            buzzer_enable <= 1'b0;
            buzzer_freq_select <= `TPB_RST_BZ_SEL;
            underflow_irq_enable <= 1'b0;
            global_irq_enable <= 1'b0;
        end else if (wr) begin
            case (paddr)
                `TPB_OFS_CTRL2: ctrl2 <= pwdata[5:0];
                `TPB_OFS_BZ_CTRL: begin
                    buzzer_enable <= pwdata[`TPB_BZ_EN];
                    buzzer_freq_select <= pwdata[3:0];
                end
                `TPB_OFS_IRQ_EN: begin
                    underflow_irq_enable <= pwdata[`TPB_IRQ_UF];
                end
                `TPB_OFS_GLOBAL: begin
                    global_irq_enable <= pwdata[`TPB_GLOBAL_GIE];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Double buffers for reload and duty
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            reload_hi <= 2'h0;
            duty_hi <= 2'h0;
            reload_val <= `TPB_RST_RELOAD;
            duty_buf <= 10'h000;
        end else if (wr) begin
            case (paddr)
                `TPB_OFS_UPPER: begin
                    reload_hi <= pwdata[`TPB_UP_RLD_HI +: 2]; // [R2]
                    duty_hi <= pwdata[`TPB_UP_DUTY_HI +: 2]; // [R18]
                end
                `TPB_OFS_RLD_LO: reload_val <= {reload_hi, pwdata[7:0]};
                `TPB_OFS_DUTY_LO: duty_buf <= {duty_hi, pwdata[7:0]};
                default: ;
            endcase
        end
    end

    // Live duty only follows the buffer at underflow
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            duty_act <= 10'h000;
        end else if (underflow) begin
            duty_act <= duty_buf; // [R18]
        end
    end

    // ------------------------------------------------------------
    // Count source: synchronised pin edge or instruction tick
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= i_external_count_clock; // [R23]
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    always_comb begin
        if (!ctrl1[`TPB_C1_RUN]) begin
            src_tick = 1'b0; // [R5]
        end else if (ctrl2[`TPB_C2_SRC]) begin
            // [R6] [R7] [R23]
            src_tick = ctrl2[`TPB_C2_EDGE] ? (ext_prev && !ext_sync)
                                           : (!ext_prev && ext_sync);
        end else begin
            src_tick = i_instr_tick; // [R6]
        end
    end

    tpb_prescaler u_prescaler (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_src_tick(src_tick),
        .i_enable_n(ctrl2[`TPB_C2_PSC_EN_N]), // [R8]
        .i_ratio(ctrl2[2:0]),
        .o_tick(cnt_tick),
        .o_count(prescaler_count_readback)
    );

    // ------------------------------------------------------------
    // Down counter
    // ------------------------------------------------------------
    assign underflow = cnt_tick && (count == 10'h000);

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= `TPB_RST_RELOAD;
        end else if (wr && paddr == `TPB_OFS_RLD_LO
                     && !ctrl1[`TPB_C1_RUN]) begin
            count <= {reload_hi, pwdata[7:0]}; // [R3]
        end else if (underflow) begin
            if (ctrl1[`TPB_C1_ONESHOT] || ctrl1[`TPB_C1_RELOAD]) begin
                count <= reload_val; // [R2] [R11]
            end else begin
                count <= `TPB_FREE_START; // [R11]
            end
        end else if (cnt_tick) begin
            count <= count - 10'h001; // [R1]
        end
    end

    // ------------------------------------------------------------
    // Underflow flag and interrupt request
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            underflow_flag <= 1'b0;
        end else if (underflow) begin
            underflow_flag <= 1'b1; // [R12] [R13]
        end else if (wr && paddr == `TPB_OFS_IRQ_FLAG
                     && !pwdata[`TPB_IRQ_UF]) begin
            underflow_flag <= 1'b0; // [R13]
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq <= 1'b0;
        end else begin
            // [R12]
            o_irq <= underflow_flag && underflow_irq_enable
                     && global_irq_enable;
        end
    end

    // ------------------------------------------------------------
    // PWM and buzzer generators
    // ------------------------------------------------------------
    // Active for duty_act counts of each frame [R16]
    assign pwm_level = (count < duty_act) ^ ctrl1[`TPB_C1_PWM_AL]; // [R15]

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            buzzer_wave_out <= 1'b0;
        end else if (buzzer_freq_select[3]) begin
            buzzer_wave_out <= count[buzzer_freq_select[2:0]]; // [R20] [R22]
        end else begin
            // [R20] [R22]
            buzzer_wave_out <=
                prescaler_count_readback[buzzer_freq_select[2:0]];
        end
    end

    // ------------------------------------------------------------
    // Pin ownership
    // ------------------------------------------------------------
    always_comb begin
        if (i_cmp_out_enable) begin
            pin_src = TPB_PIN_CMP; // [R21]
        end else if (ctrl1[`TPB_C1_PWM_EN]) begin
            pin_src = TPB_PIN_PWM; // [R14] [R21]
        end else if (buzzer_enable) begin
            pin_src = TPB_PIN_BUZ; // [R19] [R21]
        end else begin
            pin_src = TPB_PIN_NONE;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_port_b_pin3_out <= 1'b0;
            o_port_b_pin3_oe_n <= 1'b1;
        end else begin
            o_port_b_pin3_oe_n <= (pin_src == TPB_PIN_NONE);
            case (pin_src)
                TPB_PIN_CMP: o_port_b_pin3_out <= i_cmp_out;
                TPB_PIN_PWM: o_port_b_pin3_out <= pwm_level;
                TPB_PIN_BUZ: o_port_b_pin3_out <= buzzer_wave_out;
                default: o_port_b_pin3_out <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_uf_sets_flag;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        underflow |=> underflow_flag;
    endproperty
    a_uf_sets_flag: assert property (p_uf_sets_flag) // [R12]
        else $error("underflow did not set flag");

    property p_flag_sticky;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        underflow_flag && !(wr && paddr == `TPB_OFS_IRQ_FLAG)
        |=> underflow_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // [R13]
        else $error("flag cleared without software write");

    property p_irq_gate;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        underflow && underflow_irq_enable && global_irq_enable && !wr
        |=> ##1 o_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) // [R12]
        else $error("interrupt request not gated correctly");

    property p_stopped_hold;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        !ctrl1[`TPB_C1_RUN] && !wr |=> $stable(count);
    endproperty
    a_stopped_hold: assert property (p_stopped_hold) // [R5]
        else $error("counter moved while stopped");

    property p_free_start;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        underflow && !ctrl1[`TPB_C1_ONESHOT] && !ctrl1[`TPB_C1_RELOAD]
        && !wr |=> count == `TPB_FREE_START;
    endproperty
    a_free_start: assert property (p_free_start) // [R11]
        else $error("free run did not restart from top");

    property p_reload_restart;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        underflow && ctrl1[`TPB_C1_RELOAD] && !wr
        |=> count == $past(reload_val);
    endproperty
    a_reload_restart: assert property (p_reload_restart) // [R2]
        else $error("reload value not applied at underflow");

    property p_oneshot_stop;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        underflow && ctrl1[`TPB_C1_ONESHOT] && !wr
        |=> !ctrl1[`TPB_C1_RUN];
    endproperty
    a_oneshot_stop: assert property (p_oneshot_stop) // [R10]
        else $error("one-shot kept running");

    property p_stopped_load;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        wr && paddr == `TPB_OFS_RLD_LO && !ctrl1[`TPB_C1_RUN]
        |=> count[7:0] == $past(pwdata[7:0]);
    endproperty
    a_stopped_load: assert property (p_stopped_load) // [R3]
        else $error("stopped reload write not loaded");

    property p_duty_at_uf;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        !underflow |=> $stable(duty_act);
    endproperty
    a_duty_at_uf: assert property (p_duty_at_uf) // [R18]
        else $error("duty changed outside underflow");

    property p_cmp_priority;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        i_cmp_out_enable |=> !o_port_b_pin3_oe_n
                             && o_port_b_pin3_out == $past(i_cmp_out);
    endproperty
    a_cmp_priority: assert property (p_cmp_priority) // [R21]
        else $error("comparator lost pin priority");

    property p_pwm_drive;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        !i_cmp_out_enable && ctrl1[`TPB_C1_PWM_EN]
        |=> !o_port_b_pin3_oe_n && o_port_b_pin3_out == $past(pwm_level);
    endproperty
    a_pwm_drive: assert property (p_pwm_drive) // [R14]
        else $error("PWM not driven on pin");

    property p_zero_duty;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        duty_act == 10'h000 |-> pwm_level == ctrl1[`TPB_C1_PWM_AL];
    endproperty
    a_zero_duty: assert property (p_zero_duty) // [R16]
        else $error("zero duty produced active level");

    c_underflow: cover property (@(posedge i_sys_clk) underflow);
    c_oneshot: cover property (@(posedge i_sys_clk)
        underflow && ctrl1[`TPB_C1_ONESHOT]);
    c_irq: cover property (@(posedge i_sys_clk) o_irq);
    c_buzzer: cover property (@(posedge i_sys_clk)
        o_port_b_pin3_oe_n == 1'b0 && pin_src == TPB_PIN_BUZ);
endmodule : tpb_timer

// ==== tpb_pin_model.sv ====
`timescale 1ns/100ps

module tpb_pin_model (
    input wire logic i_sys_clk,
    input wire logic i_pin_out,
    input wire logic i_pin_oe_n,
    output logic o_ext_clk,
    output logic o_pad_level
);
    // ----------------------------------------
    // Pad with pull-up when no source drives
    // ----------------------------------------
    assign o_pad_level = i_pin_oe_n ? 1'b1 : i_pin_out;

    initial begin
        o_ext_clk = 1'b0;
    end

    // ----------------------------------------
    // Pin edges, each level held 6 clocks
    // ----------------------------------------
    task automatic set_level(input logic lvl);
        @(posedge i_sys_clk);
        o_ext_clk <= lvl;
        repeat (6) @(posedge i_sys_clk);
    endtask : set_level
endmodule : tpb_pin_model

// ==== tb_top.sv ====
`timescale 1ns/100ps
`include "tpb_cfg.svh"

module tb_top;
    import tpb_pkg::*;
    logic i_sys_clk, i_arst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic i_instr_tick, ext_clk, i_cmp_out, i_cmp_out_enable;
    logic pin_out, pin_oe_n, o_irq, pad;
    int mismatches = 0;
    int samples_checked = 0;

    tpb_timer tpb_timer_i (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_instr_tick(i_instr_tick),
        .i_external_count_clock(ext_clk), .i_cmp_out(i_cmp_out),
        .i_cmp_out_enable(i_cmp_out_enable),
        .o_port_b_pin3_out(pin_out), .o_port_b_pin3_oe_n(pin_oe_n),
        .o_irq(o_irq));

    tpb_pin_model tpb_pin_model_i (.i_sys_clk(i_sys_clk),
        .i_pin_out(pin_out), .i_pin_oe_n(pin_oe_n), .o_ext_clk(ext_clk),
        .o_pad_level(pad));

    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic print_verdict();
        $display("Compares %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ----------------------------------------
    // APB transfer
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge i_sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            print_verdict();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        check(r, {24'h000000, exp});
    endtask : rd

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge i_sys_clk);
            i_instr_tick <= 1'b1;
            @(posedge i_sys_clk);
            i_instr_tick <= 1'b0;
            repeat (2) @(posedge i_sys_clk);
        end
    endtask : tick

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] r;
        logic e;
        i_arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        i_instr_tick = 1'b0;
        i_cmp_out = 1'b0;
        i_cmp_out_enable = 1'b0;
        repeat (8) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        rd(`TPB_OFS_CTRL2, 8'h08);
        rd(`TPB_OFS_PSC_CNT, 8'hFF);
        rd(`TPB_OFS_UPPER, 8'h30);
        rd(`TPB_OFS_RLD_LO, 8'hFF);
        rd(`TPB_OFS_BZ_CTRL, 8'h0F);
        rd(`TPB_OFS_IRQ_FLAG, 8'h00);
        apb(1'b0, 8'h40, 8'h00, r, e);
        check({31'h0, e}, 32'h1);
        check(r, 32'h0);
        wr(`TPB_OFS_UPPER, 8'h00);
        wr(`TPB_OFS_RLD_LO, 8'h03);
        rd(`TPB_OFS_RLD_LO, 8'h03);
        wr(`TPB_OFS_IRQ_EN, 8'h08);
        wr(`TPB_OFS_GLOBAL, 8'h80);
        wr(`TPB_OFS_CTRL1, 8'h05);
        tick(3);
        rd(`TPB_OFS_RLD_LO, 8'h00);
        tick(1);
        rd(`TPB_OFS_IRQ_FLAG, 8'h08);
        rd(`TPB_OFS_CTRL1, 8'h04);
        check({31'h0, o_irq}, 32'h1);
        rd(`TPB_OFS_RLD_LO, 8'h03);
        wr(`TPB_OFS_IRQ_FLAG, 8'h08);
        rd(`TPB_OFS_IRQ_FLAG, 8'h08);
        wr(`TPB_OFS_IRQ_FLAG, 8'h00);
        rd(`TPB_OFS_IRQ_FLAG, 8'h00);
        check({31'h0, o_irq}, 32'h0);
        wr(`TPB_OFS_CTRL1, 8'h01);
        tick(4);
        rd(`TPB_OFS_UPPER, 8'h30);
        rd(`TPB_OFS_RLD_LO, 8'hFF);
        wr(`TPB_OFS_CTRL1, 8'h00);
        wr(`TPB_OFS_RLD_LO, 8'h01);
        wr(`TPB_OFS_CTRL1, 8'h03);
        wr(`TPB_OFS_UPPER, 8'h00);
        wr(`TPB_OFS_RLD_LO, 8'h02);
        rd(`TPB_OFS_RLD_LO, 8'h01);
        tick(2);
        rd(`TPB_OFS_RLD_LO, 8'h02);
        wr(`TPB_OFS_CTRL2, 8'h38);
        tick(2);
        rd(`TPB_OFS_RLD_LO, 8'h02);
        tpb_pin_model_i.set_level(1'b1);
        rd(`TPB_OFS_RLD_LO, 8'h02);
        tpb_pin_model_i.set_level(1'b0);
        rd(`TPB_OFS_RLD_LO, 8'h01);
        wr(`TPB_OFS_CTRL2, 8'h28);
        tpb_pin_model_i.set_level(1'b1);
        rd(`TPB_OFS_RLD_LO, 8'h00);
        wr(`TPB_OFS_CTRL2, 8'h00);
        wr(`TPB_OFS_CTRL1, 8'h00);
        wr(`TPB_OFS_RLD_LO, 8'h10);
        wr(`TPB_OFS_CTRL1, 8'h03);
        tick(4);
        rd(`TPB_OFS_RLD_LO, 8'h0E);
        rd(`TPB_OFS_PSC_CNT, 8'h0F);
        wr(`TPB_OFS_CTRL1, 8'hC0);
        repeat (3) @(posedge i_sys_clk);
        check({31'h0, pin_oe_n}, 32'h0);
        check({31'h0, pad}, 32'h1);
        i_cmp_out_enable <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        check({31'h0, pad}, 32'h0);
        i_cmp_out_enable <= 1'b0;
        wr(`TPB_OFS_CTRL1, 8'h00);
        wr(`TPB_OFS_BZ_CTRL, 8'h80);
        repeat (3) @(posedge i_sys_clk);
        check({31'h0, pin_oe_n}, 32'h0);
        wr(`TPB_OFS_BZ_CTRL, 8'h00);
        repeat (3) @(posedge i_sys_clk);
        check({31'h0, pin_oe_n}, 32'h1);
        wr(`TPB_OFS_UPPER, 8'h00);
        wr(`TPB_OFS_DUTY_LO, 8'h02);
        wr(`TPB_OFS_RLD_LO, 8'h04);
        wr(`TPB_OFS_CTRL2, 8'h08);
        wr(`TPB_OFS_CTRL1, 8'h83);
        tick(3);
        check({31'h0, pad}, 32'h0);
        tick(5);
        check({31'h0, pad}, 32'h1);
        wr(`TPB_OFS_CTRL1, 8'hC3);
        repeat (3) @(posedge i_sys_clk);
        check({31'h0, pad}, 32'h0);
        wr(`TPB_OFS_CTRL1, 8'h00);
        wr(`TPB_OFS_BZ_CTRL, 8'h88);
        repeat (3) @(posedge i_sys_clk);
        check({31'h0, pad}, 32'h1);
        wr(`TPB_OFS_BZ_CTRL, 8'h89);
        repeat (3) @(posedge i_sys_clk);
        check({31'h0, pad}, 32'h0);
        print_verdict();
    end
endmodule : tb_top
